// ### inc/radio_mode_pkg.sv
// Constants shared by the radio mode control register bank.
// Assumes an 8-bit register space addressed by a 10-bit index.
package radio_mode_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int TRIM_W = 7;
  localparam int LOCK_W = 16;

  localparam logic [ADDR_W-1:0] PHASE_TRIM_OFFSET = 10'h118;
  localparam logic [ADDR_W-1:0] AMPLITUDE_TRIM_OFFSET = 10'h119;
  localparam logic [ADDR_W-1:0] MODE_CONTROL_OFFSET = 10'h11a;

  localparam int SMART_WAKE_BIT = 7;
  localparam int IF_CAL_BIT = 6;
  localparam int RSSI_QUAL_BIT = 5;
  localparam int TX_TO_RX_BIT = 4;
  localparam int RX_TO_TX_BIT = 3;
  localparam int CUSTOM_LOCK_BIT = 2;
  localparam int EXT_LNA_BIT = 1;
  localparam int EXT_PA_BIT = 0;

  localparam logic [TRIM_W-1:0] TRIM_RESET = 7'h00;
  localparam logic [DATA_W-1:0] MODE_CONTROL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_DATA_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
  localparam logic [LOCK_W-1:0] DEFAULT_LOCK_TIME = 16'h0000;

  typedef enum logic [2:0] {
    RADIO_SLEEP = 3'b000,
    RADIO_OFF_STATE = 3'b001,
    RADIO_ON_STATE = 3'b010,
    RECEIVE_STATE = 3'b011,
    TRANSMIT_STATE = 3'b100
  } radio_state_e;

endpackage

// ### design/amp_pin_driver.sv
// Drives one external amplifier enable onto a shared test pin.
// Assumes the radio state comes from logic on the same clock.
`timescale 1ns/1ps
module amp_pin_driver
  import radio_mode_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic driveEnable,
  input wire radio_state_e radioState,
  input wire radio_state_e activeState,
  output logic pinOut,
  output logic pinOe
);

  logic pinOut_nxt;
  logic pinOe_nxt;

  always_comb begin
    // Released pin stays free for its other uses
    pinOe_nxt = driveEnable; // R12
    pinOut_nxt = driveEnable && (radioState == activeState); // R10 R11
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pinOut <= 1'b0;
      pinOe <= 1'b0;
    end else begin
      pinOut <= pinOut_nxt;
      pinOe <= pinOe_nxt;
    end
  end

endmodule

// ### design/radio_mode_control_regs.sv
// Image-rejection trim and radio mode control register bank.
// Assumes a single-cycle register port and a radio state machine
// on the same clock that reports its state and packet events.
// Function
// R1 - The phase trim register's low seven bits drive the I/Q phase correction, bit 7 is zero.
// R2 - The amplitude trim register's low seven bits drive the I/Q amplitude correction.
// R3 - Mode control bit 7 turns smart wake operation on or off.
// R4 - With bit 6 set, each off-to-on transition starts an IF filter calibration.
// R5 - Mode control bit 5 turns RSSI qualification in low-power smart wake on or off.
// R6 - With bit 4 set, a finished packet transmission leads straight into receive.
// R7 - With bit 3 set, a valid received packet leads straight into transmit.
// R8 - Both automatic turnarounds act only in packet mode.
// R9 - Bit 2 picks the custom synthesizer lock time over the default one.
// R10 - With bit 1 set, the LNA test pin is high in receive and low in other awake states.
// R11 - With bit 0 set, the PA test pin is high in transmit and low in other awake states.
// R12 - With an amplifier bit clear, its test pin is not driven by this block.
`timescale 1ns/1ps
module radio_mode_control_regs
  import radio_mode_pkg::*;
#(
  parameter logic [LOCK_W-1:0] DEFAULT_LOCK = DEFAULT_LOCK_TIME
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regRdEn,
  output logic [DATA_W-1:0] regRdData,
  input wire radio_state_e radioState,
  input wire logic packetMode,
  input wire logic txPacketDone,
  input wire logic rxPacketValid,
  input wire logic [LOCK_W-1:0] customLockTime,
  output logic [TRIM_W-1:0] phaseTrim,
  output logic [TRIM_W-1:0] amplitudeTrim,
  output logic smartWakeEnable,
  output logic lowPowerRssiQualify,
  output logic ifFilterCalStart,
  output logic autoEnterReceive,
  output logic autoEnterTransmit,
  output logic [LOCK_W-1:0] synthLockTime,
  output logic testPinLnaOut,
  output logic testPinLnaOe,
  output logic testPinPaOut,
  output logic testPinPaOe
);

  logic [TRIM_W-1:0] phaseTrim_r;
  logic [TRIM_W-1:0] phaseTrim_nxt;
  logic [TRIM_W-1:0] amplitudeTrim_r;
  logic [TRIM_W-1:0] amplitudeTrim_nxt;
  logic [DATA_W-1:0] modeControl_r;
  logic [DATA_W-1:0] modeControl_nxt;
  logic [DATA_W-1:0] regRdData_nxt;

  radio_state_e prevState_r;
  radio_state_e prevState_nxt;
  logic smartWakeEnable_nxt;
  logic lowPowerRssiQualify_nxt;
  logic ifFilterCalStart_nxt;
  logic autoEnterReceive_nxt;
  logic autoEnterTransmit_nxt;
  logic [LOCK_W-1:0] synthLockTime_nxt;

  logic wrPhase;
  logic wrAmplitude;
  logic wrMode;

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offset);
    hit = (addr == offset);
  endfunction

  function automatic logic in_state(input radio_state_e state, input radio_state_e wanted);
    in_state = (state == wanted);
  endfunction

  // Reserved top bit of a trim register always reads zero
  function automatic logic [DATA_W-1:0] trim_readback(input logic [TRIM_W-1:0] trim);
    trim_readback = {{(DATA_W-TRIM_W){1'b0}}, trim};
  endfunction

  // Write strobes per register
  always_comb begin
    wrPhase = regWrEn && hit(regAddr, PHASE_TRIM_OFFSET);
    wrAmplitude = regWrEn && hit(regAddr, AMPLITUDE_TRIM_OFFSET);
    wrMode = regWrEn && hit(regAddr, MODE_CONTROL_OFFSET);
  end

  // Trim registers
  always_comb begin
    phaseTrim_nxt = phaseTrim_r;
    amplitudeTrim_nxt = amplitudeTrim_r;
    if (wrPhase) begin
      phaseTrim_nxt = regWrData[TRIM_W-1:0]; // R1
    end
    if (wrAmplitude) begin
      amplitudeTrim_nxt = regWrData[TRIM_W-1:0]; // R2
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      phaseTrim_r <= TRIM_RESET;
      amplitudeTrim_r <= TRIM_RESET;
    end else begin
      phaseTrim_r <= phaseTrim_nxt;
      amplitudeTrim_r <= amplitudeTrim_nxt;
    end
  end

  // Mode control register
  always_comb begin
    modeControl_nxt = modeControl_r;
    if (wrMode) begin
      modeControl_nxt = regWrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      modeControl_r <= MODE_CONTROL_RESET;
    end else begin
      modeControl_r <= modeControl_nxt;
    end
  end

  // Read data holds between reads; a same-cycle write is not yet seen
  always_comb begin
    regRdData_nxt = regRdData;
    if (regRdEn) begin
      if (hit(regAddr, PHASE_TRIM_OFFSET)) begin
        regRdData_nxt = trim_readback(phaseTrim_r); // R1
      end else if (hit(regAddr, AMPLITUDE_TRIM_OFFSET)) begin
        regRdData_nxt = trim_readback(amplitudeTrim_r); // R2
      end else if (hit(regAddr, MODE_CONTROL_OFFSET)) begin
        regRdData_nxt = modeControl_r;
      end else begin
        regRdData_nxt = UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      regRdData <= READ_DATA_RESET;
    end else begin
      regRdData <= regRdData_nxt;
    end
  end

  // Radio state one cycle back, for the off-to-on edge
  always_comb begin
    prevState_nxt = radioState;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      prevState_r <= RADIO_SLEEP;
    end else begin
      prevState_r <= prevState_nxt;
    end
  end

  // Mode decisions toward the radio state machine
  always_comb begin
    smartWakeEnable_nxt = modeControl_nxt[SMART_WAKE_BIT]; // R3
    lowPowerRssiQualify_nxt = modeControl_nxt[RSSI_QUAL_BIT]; // R5
    ifFilterCalStart_nxt = modeControl_r[IF_CAL_BIT] && in_state(prevState_r, RADIO_OFF_STATE)
      && in_state(radioState, RADIO_ON_STATE); // R4
    // Turnarounds are gated by packet mode
    autoEnterReceive_nxt = modeControl_r[TX_TO_RX_BIT] && packetMode // R8
      && txPacketDone && in_state(radioState, TRANSMIT_STATE); // R6
    autoEnterTransmit_nxt = modeControl_r[RX_TO_TX_BIT] && packetMode // R8
      && rxPacketValid && in_state(radioState, RECEIVE_STATE); // R7
    synthLockTime_nxt = modeControl_r[CUSTOM_LOCK_BIT] ? customLockTime : DEFAULT_LOCK; // R9
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      phaseTrim <= TRIM_RESET;
      amplitudeTrim <= TRIM_RESET;
      smartWakeEnable <= 1'b0;
      lowPowerRssiQualify <= 1'b0;
      ifFilterCalStart <= 1'b0;
      autoEnterReceive <= 1'b0;
      autoEnterTransmit <= 1'b0;
      synthLockTime <= DEFAULT_LOCK;
    end else begin
      phaseTrim <= phaseTrim_nxt; // R1
      amplitudeTrim <= amplitudeTrim_nxt; // R2
      smartWakeEnable <= smartWakeEnable_nxt; // R3
      lowPowerRssiQualify <= lowPowerRssiQualify_nxt; // R5
      ifFilterCalStart <= ifFilterCalStart_nxt;
      autoEnterReceive <= autoEnterReceive_nxt;
      autoEnterTransmit <= autoEnterTransmit_nxt;
      synthLockTime <= synthLockTime_nxt;
    end
  end

  // Amplifier enables on the shared test pins
  amp_pin_driver lnaPin (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .driveEnable(modeControl_r[EXT_LNA_BIT]), // R10
    .radioState(radioState),
    .activeState(RECEIVE_STATE),
    .pinOut(testPinLnaOut),
    .pinOe(testPinLnaOe)
  );

  amp_pin_driver paPin (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .driveEnable(modeControl_r[EXT_PA_BIT]), // R11
    .radioState(radioState),
    .activeState(TRANSMIT_STATE),
    .pinOut(testPinPaOut),
    .pinOe(testPinPaOe)
  );

endmodule

// ### verif/radio_mode_assertions.sv
// Checker for the radio mode register bank.
// Sees only the top module ports; bound below.
`timescale 1ns/1ps
module radio_mode_assertions
  import radio_mode_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic packetMode,
  input wire logic txPacketDone,
  input wire logic rxPacketValid,
  input wire radio_state_e radioState,
  input wire logic ifFilterCalStart,
  input wire logic autoEnterReceive,
  input wire logic autoEnterTransmit,
  input wire logic testPinLnaOut,
  input wire logic testPinLnaOe,
  input wire logic testPinPaOut,
  input wire logic testPinPaOe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  chk_cal_after_on: assert property (ifFilterCalStart |-> $past(radioState) == RADIO_ON_STATE
    && $past(radioState, 2) == RADIO_OFF_STATE) else $error("cal pulse without off to on");
  chk_cal_one_cycle: assert property (ifFilterCalStart |=> !ifFilterCalStart)
    else $error("cal pulse too long");
  chk_rx_turn_cause: assert property (autoEnterReceive |-> $past(packetMode && txPacketDone
    && radioState == TRANSMIT_STATE)) else $error("receive turnaround without cause");
  chk_tx_turn_cause: assert property (autoEnterTransmit |-> $past(packetMode && rxPacketValid
    && radioState == RECEIVE_STATE)) else $error("transmit turnaround without cause");
  chk_lna_pin_state: assert property (testPinLnaOut |-> testPinLnaOe
    && $past(radioState) == RECEIVE_STATE) else $error("lna pin high off receive");
  chk_pa_pin_state: assert property (testPinPaOut |-> testPinPaOe
    && $past(radioState) == TRANSMIT_STATE) else $error("pa pin high off transmit");
  chk_lna_pin_high: assert property (testPinLnaOe && $past(testPinLnaOe)
    && $past(radioState) == RECEIVE_STATE |-> testPinLnaOut) else $error("lna pin low in receive");
  chk_pa_pin_high: assert property (testPinPaOe && $past(testPinPaOe)
    && $past(radioState) == TRANSMIT_STATE |-> testPinPaOut) else $error("pa pin low in transmit");
endmodule
bind radio_mode_control_regs radio_mode_assertions radio_mode_assertions_i (.ref_clk, .reset_n,
  .packetMode, .txPacketDone, .rxPacketValid, .radioState, .ifFilterCalStart, .autoEnterReceive,
  .autoEnterTransmit, .testPinLnaOut, .testPinLnaOe, .testPinPaOut, .testPinPaOe);

// ### verif/radio_fsm_model.sv
// Stand-in radio state machine feeding the bank.
// Follows bench requests and the turnaround pulses.
`timescale 1ns/1ps
module radio_fsm_model
  import radio_mode_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire radio_state_e wantState,
  input wire logic stateGo,
  input wire logic toRx,
  input wire logic toTx,
  output radio_state_e radioState
);
  always_ff @(posedge ref_clk) begin
    if (!reset_n) radioState <= RADIO_SLEEP;
    else if (toRx) radioState <= RECEIVE_STATE;
    else if (toTx) radioState <= TRANSMIT_STATE;
    else if (stateGo) radioState <= wantState;
  end
endmodule

// ### verif/radio_mode_control_regs_tb.sv
// Self-checking bench for the radio mode register bank.
// Drives the register port; a model drives the radio state.
`timescale 1ns/1ps
module radio_mode_control_regs_tb import radio_mode_pkg::*; ;
  logic ref_clk = 0, reset_n = 0, regWrEn = 0, regRdEn = 0, packetMode = 0, rdSeen = 0;
  logic txPacketDone = 0, rxPacketValid = 0, stateGo = 0, smartWakeEnable, lowPowerRssiQualify;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0, regRdData, v;
  logic [LOCK_W-1:0] customLockTime = '0, synthLockTime;
  logic [TRIM_W-1:0] phaseTrim, amplitudeTrim;
  logic ifFilterCalStart, autoEnterReceive, autoEnterTransmit;
  logic testPinLnaOut, testPinLnaOe, testPinPaOut, testPinPaOe;
  radio_state_e radioState, wantState = RADIO_SLEEP;
  logic [7:0] expQ[$];
  int failures = 0, n_compared = 0, cycles = 0;
  radio_mode_control_regs radio_mode_control_regs_i (.ref_clk, .reset_n, .regAddr, .regWrEn,
    .regWrData, .regRdEn, .regRdData, .radioState, .packetMode, .txPacketDone, .rxPacketValid,
    .customLockTime, .phaseTrim, .amplitudeTrim, .smartWakeEnable, .lowPowerRssiQualify,
    .ifFilterCalStart, .autoEnterReceive, .autoEnterTransmit, .synthLockTime, .testPinLnaOut,
    .testPinLnaOe, .testPinPaOut, .testPinPaOe);
  radio_fsm_model radio_fsm_model_i (.ref_clk, .reset_n, .wantState, .stateGo,
    .toRx(autoEnterReceive), .toTx(autoEnterTransmit), .radioState);
  task automatic tick(int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic cmp(logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_read(logic [7:0] got, logic [7:0] exp);
    cmp(16'(got), 16'(exp));
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(logic [9:0] a, logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1;
    tick();
    regWrEn = 0;
    tick();
  endtask
  task automatic rd(logic [9:0] a, logic [7:0] e);
    regAddr = a;
    regRdEn = 1;
    expQ.push_back(e);
    tick();
    regRdEn = 0;
    tick();
  endtask
  task automatic go(radio_state_e s);
    wantState = s;
    stateGo = 1;
    tick();
    stateGo = 0;
    tick();
  endtask
  always @(posedge ref_clk) begin
    rdSeen <= regRdEn;
    if (rdSeen) cmp_read(regRdData, expQ.pop_front());
    cycles++;
    if (cycles > 3000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    void'($urandom(32'he6ecae0a));
    tick(20);
    reset_n = 1;
    wr(10'h11b, 8'hff);
    rd(10'h11b, 8'h00);
    rd(MODE_CONTROL_OFFSET, 8'h00);
    repeat (4) begin
      v = 8'($urandom);
      wr(PHASE_TRIM_OFFSET, v);
      wr(AMPLITUDE_TRIM_OFFSET, ~v);
      rd(PHASE_TRIM_OFFSET, v & 8'h7f);
      rd(AMPLITUDE_TRIM_OFFSET, ~v & 8'h7f);
      cmp(16'({phaseTrim, amplitudeTrim}), 16'({v[6:0], ~v[6:0]}));
    end
    for (int i = 0; i < 8; i++) begin
      wr(MODE_CONTROL_OFFSET, 8'h01 << i);
      rd(MODE_CONTROL_OFFSET, 8'h01 << i);
      cmp(16'({smartWakeEnable, lowPowerRssiQualify}), 16'({i == 7, i == 5}));
      cmp(16'({testPinLnaOe, testPinPaOe}), 16'({i == 1, i == 0}));
    end
    customLockTime = 16'($urandom);
    wr(MODE_CONTROL_OFFSET, 8'h04);
    cmp(synthLockTime, customLockTime);
    wr(MODE_CONTROL_OFFSET, 8'h00);
    cmp(synthLockTime, DEFAULT_LOCK_TIME);
    for (int b = 0; b < 2; b++) begin
      wr(MODE_CONTROL_OFFSET, b[0] ? 8'h40 : 8'h00);
      go(RADIO_OFF_STATE);
      go(RADIO_ON_STATE);
      cmp(16'(ifFilterCalStart), 16'(b));
    end
    wr(MODE_CONTROL_OFFSET, 8'h1b);
    for (int m = 0; m < 4; m++) begin
      packetMode = m[1];
      go(m[0] ? RECEIVE_STATE : TRANSMIT_STATE);
      cmp(16'({testPinLnaOut, testPinPaOut}), 16'({m[0], !m[0]}));
      txPacketDone = !m[0];
      rxPacketValid = m[0];
      tick();
      txPacketDone = 0;
      rxPacketValid = 0;
      cmp(16'({autoEnterReceive, autoEnterTransmit}), 16'({m[1] & !m[0], m[1] & m[0]}));
      tick(2);
      cmp(16'({testPinLnaOut, testPinPaOut}), 16'({m[0] ^ m[1], !(m[0] ^ m[1])}));
    end
    tick(3);
    reset_n = 0;
    tick(2);
    reset_n = 1;
    cmp(16'({testPinLnaOe, testPinPaOe, smartWakeEnable, ifFilterCalStart}), 16'h0000);
    rd(PHASE_TRIM_OFFSET, {1'b0, TRIM_RESET});
    rd(MODE_CONTROL_OFFSET, MODE_CONTROL_RESET);
    cmp(synthLockTime, DEFAULT_LOCK_TIME);
    tick(3);
    tally_and_finish();
  end
endmodule
